// ===== logic/pixcorr_pkg.sv
`default_nettype none
package pixcorr_pkg;
	localparam int PIX_W       = 12;
	localparam int NUM_PIX     = 256;
	localparam int ADDR_W      = 8;
	localparam int COEF_W      = 16;
	localparam int NUM_SLOTS   = 4;
	localparam int SLOT_W      = 2;
	localparam int NUM_OUTS    = 4;
	localparam int CALIB_LINES = 8;
	localparam int CALIB_SH    = 3;
	localparam int GAIN_FRAC   = 12;
	localparam int ROW_GAIN_MAX = 16'h3FFF;
	localparam int SYS_GAIN_MAX = 16'hA000;
	localparam int CLK_MHZ     = 50;
	// light source must wait this long after the trigger edge
	localparam int STROBE_MIN_NS     = 1400;
	localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int READOUT_CYCLES    = 8;
	// dark-current band, as line rates in kHz and as clock cycles per line
	localparam int RATE_LO_KHZ   = 4;
	localparam int RATE_HI_KHZ   = 60;
	localparam int FACT_RATE_KHZ = 100;
	localparam int PERIOD_LO_CYC = CLK_MHZ * 1000 / RATE_LO_KHZ;
	localparam int PERIOD_HI_CYC = CLK_MHZ * 1000 / RATE_HI_KHZ;
	localparam int FACT_PERIOD_CYC = CLK_MHZ * 1000 / FACT_RATE_KHZ;
	// register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_PEDESTAL  = 8'h04;
	localparam logic [7:0] REG_ROW_GAIN0 = 8'h08;
	localparam logic [7:0] REG_ROW_GAIN1 = 8'h0C;
	localparam logic [7:0] REG_SYS_GAIN  = 8'h10;
	localparam logic [7:0] REG_TARGET    = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h18;
	localparam logic [7:0] REG_PERIOD    = 8'h1C;
	localparam logic [7:0] REG_OUT0      = 8'h20;
	localparam logic [15:0] UNITY_GAIN   = 16'h1000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
	typedef enum logic [1:0] {
		GCAL_PEAK          = 2'b00,
		GCAL_TARGET        = 2'b01,
		GCAL_PEAK_FILT     = 2'b10,
		GCAL_TARGET_FILT   = 2'b11
	} gain_cal_e;
	typedef enum logic [1:0] {
		OSRC_OFF      = 2'b00,
		OSRC_EXPOSURE = 2'b01,
		OSRC_TRIGGER  = 2'b10,
		OSRC_HIGH     = 2'b11
	} out_src_e;
	typedef struct packed {
		logic           valid;
		logic           last;
		logic [PIX_W-1:0] data;
	} pix_s;
	typedef struct packed {
		out_src_e     src;
		logic         invert;
		logic [11:0]  delay;
		logic [11:0]  width;
	} out_cfg_s;
endpackage
`default_nettype wire

// ===== logic/coef_mem.sv
`default_nettype none
module coef_mem
	import pixcorr_pkg::*;
#(
	parameter int DW = 2 * COEF_W,
	parameter int AW = SLOT_W + ADDR_W
) (
	input  wire logic          ref_clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [DW-1:0] wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [DW-1:0] rdata_out
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	always_ff @(posedge ref_clk_in) begin
		if (we_in) begin
			mem_q[waddr_in] <= wdata_in;
		end
		rdata_out <= mem_q[raddr_in];
	end
endmodule
`default_nettype wire

// ===== logic/pixel_correction_and_strobe.sv
// Design decisions made here: the register offsets and register access over Avalon-MM.
`default_nettype none
module pixel_correction_and_strobe
	import pixcorr_pkg::*;
(
	input  wire logic                ref_clk_in,
	input  wire logic                rst_n_in,
	input  wire logic [7:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                line_trigger_input,
	input  wire pix_s                sensor_pix_in,
	output logic                     readout_start_out,
	output pix_s                     pix_out,
	output logic [NUM_OUTS-1:0]      gpio_out
);
	// ============================================================
	// register file
	logic              ack_q;
	logic              mono_q, shared_q, row_sel_q, dark_mode_q;
	gain_cal_e         gmethod_q;
	logic [SLOT_W-1:0] slot_q;
	logic signed [15:0] pedestal_offset_q;
	logic [15:0]       row_gain_q [2];
	logic [15:0]       sys_gain_q;
	logic [PIX_W-1:0]  calibration_target_level_q;
	logic              ocal_go_q, gcal_go_q, busy_q;
	out_cfg_s          out_cfg_q [NUM_OUTS];
	logic [31:0]       period_q;
	wire sel = (avs_read | avs_write) & ~ack_q;
	// a write lands at the edge that ends the wait, as the master sees it
	wire wr  = avs_write & ack_q;
	logic [7:0] oidx;
	assign oidx = avs_address - REG_OUT0;

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_q <= sel;
			avs_waitrequest <= ~sel;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			mono_q <= 1'b1;
			shared_q <= 1'b1;
			row_sel_q <= 1'b0;
			dark_mode_q <= 1'b0;
			gmethod_q <= GCAL_PEAK;
			slot_q <= '0;
			pedestal_offset_q <= '0;
			row_gain_q[0] <= UNITY_GAIN;
			row_gain_q[1] <= UNITY_GAIN;
			sys_gain_q <= UNITY_GAIN;
			calibration_target_level_q <= '0;
			ocal_go_q <= 1'b0;
			gcal_go_q <= 1'b0;
			for (int i = 0; i < NUM_OUTS; i++) begin
				out_cfg_q[i] <= '0;
			end
		end else begin
			ocal_go_q <= 1'b0;
			gcal_go_q <= 1'b0;
			if (wr && avs_address == REG_CTRL) begin
				mono_q <= avs_writedata[0];
				shared_q <= avs_writedata[1];
				row_sel_q <= avs_writedata[2];
				dark_mode_q <= avs_writedata[3];
				gmethod_q <= gain_cal_e'(avs_writedata[5:4]);
				slot_q <= avs_writedata[9:8];
				ocal_go_q <= avs_writedata[16];
				gcal_go_q <= avs_writedata[17];
			end else if (wr && avs_address == REG_PEDESTAL) begin
				pedestal_offset_q <= avs_writedata[15:0];
			end else if (wr && (avs_address == REG_ROW_GAIN0 || avs_address == REG_ROW_GAIN1)) begin
				row_gain_q[avs_address[2]] <= (avs_writedata[15:0] < UNITY_GAIN) ? UNITY_GAIN :
					(avs_writedata[15:0] > 16'(ROW_GAIN_MAX)) ? 16'(ROW_GAIN_MAX) : avs_writedata[15:0];
			end else if (wr && avs_address == REG_SYS_GAIN) begin
				sys_gain_q <= (avs_writedata[15:0] < UNITY_GAIN) ? UNITY_GAIN :
					(avs_writedata[15:0] > 16'(SYS_GAIN_MAX)) ? 16'(SYS_GAIN_MAX) : avs_writedata[15:0];
			end else if (wr && avs_address == REG_TARGET) begin
				calibration_target_level_q <= avs_writedata[PIX_W-1:0];
			end else if (wr && avs_address >= REG_OUT0 && oidx < 8'(4*NUM_OUTS)) begin
				out_cfg_q[oidx[3:2]] <= avs_writedata[26:0];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			avs_readdata <= '0;
		end else if (sel) begin
			if (avs_address == REG_CTRL) begin
				avs_readdata <= {14'h0, 2'b00, 6'h0, slot_q, 2'b00, gmethod_q,
					dark_mode_q, row_sel_q, shared_q, mono_q};
			end else if (avs_address == REG_PEDESTAL) begin
				avs_readdata <= 32'(pedestal_offset_q);
			end else if (avs_address == REG_ROW_GAIN0) begin
				avs_readdata <= {16'h0, row_gain_q[0]};
			end else if (avs_address == REG_ROW_GAIN1) begin
				avs_readdata <= {16'h0, row_gain_q[1]};
			end else if (avs_address == REG_SYS_GAIN) begin
				avs_readdata <= {16'h0, sys_gain_q};
			end else if (avs_address == REG_TARGET) begin
				avs_readdata <= 32'(calibration_target_level_q);
			end else if (avs_address == REG_STATUS) begin
				avs_readdata <= {31'h0, busy_q};
			end else if (avs_address == REG_PERIOD) begin
				avs_readdata <= period_q;
			end else if (avs_address >= REG_OUT0 && oidx < 8'(4*NUM_OUTS)) begin
				avs_readdata <= 32'(out_cfg_q[oidx[3:2]]);
			end else begin
				avs_readdata <= UNMAPPED_VAL;
			end
		end
	end

	// ============================================================
	// trigger, readout and line period
	logic trig_q, pend_q;
	logic [7:0]  ro_cnt_q;
	logic [31:0] pcnt_q;
	wire trig_rise = line_trigger_input & ~trig_q;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			trig_q <= 1'b0;
			readout_start_out <= 1'b0;
			ro_cnt_q <= '0;
			pend_q <= 1'b0;
			pcnt_q <= '0;
			period_q <= 32'(FACT_PERIOD_CYC);
		end else begin
			trig_q <= line_trigger_input;
			readout_start_out <= trig_rise;
			if (trig_rise) begin
				ro_cnt_q <= 8'(READOUT_CYCLES);
				pcnt_q <= '0;
				period_q <= pcnt_q;
			end else begin
				pcnt_q <= (pcnt_q == 32'hFFFF_FFFF) ? pcnt_q : pcnt_q + 32'd1;
				if (ro_cnt_q != 0) begin
					ro_cnt_q <= ro_cnt_q - 8'd1;
				end
			end
			pend_q <= (ro_cnt_q == 8'd1);
		end
	end
	logic line_act_q;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			line_act_q <= 1'b0;
		end else if (pend_q) begin
			line_act_q <= 1'b1;
		end else if (sensor_pix_in.valid && sensor_pix_in.last) begin
			line_act_q <= 1'b0;
		end
	end

	// ============================================================
	// dark-current scale, q12 relative to factory rate
	// scale reaches well above 16 in q12 at the slow band edge
	logic [16:0] dscale_q;
	logic [31:0] pclamp;
	assign pclamp = (period_q > 32'(PERIOD_LO_CYC)) ? 32'(PERIOD_LO_CYC) :
		(period_q < 32'(PERIOD_HI_CYC)) ? 32'(PERIOD_HI_CYC) : period_q;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			dscale_q <= 17'(UNITY_GAIN);
		end else begin
			dscale_q <= 17'((pclamp << GAIN_FRAC) / 32'(FACT_PERIOD_CYC));
		end
	end

	// ============================================================
	// coefficient memory and pixel pipeline
	logic [ADDR_W-1:0] px_q;
	// pixel index carried along with the data through stages 0 and 1
	logic [ADDR_W-1:0] px0_q;
	logic [ADDR_W-1:0] px1_q;
	logic [ADDR_W-1:0] rd_px;
	logic              cmem_we;
	logic [SLOT_W+ADDR_W-1:0] cmem_wa;
	logic [2*COEF_W-1:0] cmem_wd, cmem_rd;
	coef_mem u_mem (
		.ref_clk_in(ref_clk_in),
		.we_in     (cmem_we),
		.waddr_in  (cmem_wa),
		.wdata_in  (cmem_wd),
		.raddr_in  ({slot_q, rd_px}),
		.rdata_out (cmem_rd)
	);
	pix_s s0_q, s1_q;
	logic signed [20:0] s1_val_q;
	logic [31:0] s2_q;
	logic s2_v_q, s2_l_q, rsel_q;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			px_q <= '0;
			px0_q <= '0;
			s0_q <= '0;
		end else begin
			s0_q <= (sensor_pix_in.valid && line_act_q) ? sensor_pix_in : '0;
			if (sensor_pix_in.valid && line_act_q) begin
				px0_q <= px_q;
				px_q <= sensor_pix_in.last ? '0 : px_q + 1'b1;
			end
		end
	end
	logic [31:0] off_s;
	logic signed [20:0] ffc;
	logic [31:0] g1, g2;
	assign off_s = dark_mode_q ? 32'((48'(cmem_rd[15:0]) * 48'(dscale_q)) >> GAIN_FRAC)
		: 32'(cmem_rd[15:0]);
	always_comb begin
		ffc = 21'(((33'(s0_q.data) - 33'(off_s)) * 33'(cmem_rd[31:16])) >>> GAIN_FRAC);
	end
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			s1_q <= '0;
			s1_val_q <= '0;
			s2_q <= '0;
			s2_v_q <= 1'b0;
			s2_l_q <= 1'b0;
			rsel_q <= 1'b0;
			px1_q <= '0;
			pix_out <= '0;
		end else begin
			s1_q <= s0_q;
			px1_q <= px0_q;
			s1_val_q <= ((ffc[20] ? 21'sd0 : ffc) + 21'(pedestal_offset_q));
			if (s1_q.valid && s1_q.last) begin
				rsel_q <= ~rsel_q;
			end
			s2_v_q <= s1_q.valid;
			s2_l_q <= s1_q.last;
			s2_q <= s1_val_q[20] ? 32'd0 : g1;
			pix_out.valid <= s2_v_q;
			pix_out.last <= s2_l_q;
			pix_out.data <= (g2 > 32'((1 << PIX_W) - 1)) ? PIX_W'((1 << PIX_W) - 1)
				: g2[PIX_W-1:0];
		end
	end
	wire rg = (mono_q | shared_q) ? row_sel_q : rsel_q;
	// wide products so large values saturate instead of wrapping
	assign g1 = 32'((40'(s1_val_q[19:0]) * 40'(row_gain_q[rg])) >> GAIN_FRAC);
	assign g2 = 32'((48'(s2_q) * 48'(sys_gain_q)) >> GAIN_FRAC);

	// ============================================================
	// calibration: accumulate, filter, compute, commit
	logic [19:0] acc_q [NUM_PIX];
	logic [3:0]  lines_q;
	logic        mode_gain_q, calc_q;
	logic [ADDR_W:0] ci_q;
	logic [PIX_W-1:0] peak_q;
	logic [PIX_W-1:0] avg [NUM_PIX];
	always_comb begin
		for (int i = 0; i < NUM_PIX; i++) begin
			avg[i] = PIX_W'(acc_q[i] >> CALIB_SH);
		end
	end
	logic [PIX_W+1:0] fil;
	logic [PIX_W-1:0] lvl, ref_lvl;
	logic [ADDR_W-1:0] cidx, cl, cr;
	assign cidx = ci_q[ADDR_W-1:0];
	assign cl = (cidx == 0) ? cidx : cidx - 1'b1;
	assign cr = (cidx == ADDR_W'(NUM_PIX-1)) ? cidx : cidx + 1'b1;
	// read one pixel ahead while computing, so the stored offset is ready at its write
	assign rd_px = calc_q ? cidx + 1'b1 : px_q;
	assign fil = 14'(avg[cl]) + 14'({avg[cidx], 1'b0}) + 14'(avg[cr]);
	assign lvl = gmethod_q[1] ? fil[PIX_W+1:2] : avg[cidx];
	assign ref_lvl = gmethod_q[0] ? calibration_target_level_q : peak_q;
	wire [15:0] old_off = cmem_rd[15:0];
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			busy_q <= 1'b0;
			lines_q <= '0;
			mode_gain_q <= 1'b0;
			calc_q <= 1'b0;
			ci_q <= '0;
			peak_q <= '0;
			cmem_we <= 1'b0;
			cmem_wa <= '0;
			cmem_wd <= '0;
			for (int i = 0; i < NUM_PIX; i++) begin
				acc_q[i] <= '0;
			end
		end else begin
			cmem_we <= 1'b0;
			if (!busy_q && (ocal_go_q || gcal_go_q)) begin
				busy_q <= 1'b1;
				mode_gain_q <= gcal_go_q;
				lines_q <= '0;
				peak_q <= '0;
				for (int i = 0; i < NUM_PIX; i++) begin
					acc_q[i] <= '0;
				end
			end else if (busy_q && !calc_q) begin
				// average dark or offset-subtracted lit lines
				if (s1_q.valid) begin
					acc_q[px1_q] <= acc_q[px1_q] + 20'(mode_gain_q ?
						((s1_val_q[20]) ? 16'd0 : s1_val_q[15:0]) : 16'(s1_q.data));
					if (s1_q.last) begin
						lines_q <= lines_q + 1'b1;
						if (lines_q == 4'(CALIB_LINES-1)) begin
							calc_q <= 1'b1;
							ci_q <= '0;
						end
					end
				end
			end else if (calc_q) begin
				if (ci_q[ADDR_W] == 1'b0) begin
					ci_q <= ci_q + 1'b1;
					if (lvl > peak_q) begin
						peak_q <= lvl;
					end
				end else begin
					ci_q <= ci_q + 1'b1;
				end
				if (ci_q[ADDR_W] && !mode_gain_q) begin
					cmem_we <= 1'b1;
					cmem_wa <= {slot_q, cidx};
					cmem_wd <= {UNITY_GAIN, 16'(avg[cidx])};
				end else if (ci_q[ADDR_W]) begin
					cmem_we <= 1'b1;
					cmem_wa <= {slot_q, cidx};
					cmem_wd <= {(lvl == 0) ? UNITY_GAIN :
						16'((32'(ref_lvl) << GAIN_FRAC) / 32'(lvl)), old_off};
				end
				if (ci_q == {1'b1, {ADDR_W{1'b1}}}) begin
					calc_q <= 1'b0;
					busy_q <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// strobe outputs
	logic exp_q;
	logic [11:0] dly_q [NUM_OUTS];
	logic [11:0] wid_q [NUM_OUTS];
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			exp_q <= 1'b0;
		end else begin
			exp_q <= line_trigger_input;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			gpio_out <= '0;
			for (int i = 0; i < NUM_OUTS; i++) begin
				dly_q[i] <= '0;
				wid_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_OUTS; i++) begin
				if (trig_rise) begin
					dly_q[i] <= out_cfg_q[i].delay;
					wid_q[i] <= '0;
				end else if (dly_q[i] != 0) begin
					dly_q[i] <= dly_q[i] - 1'b1;
					if (dly_q[i] == 12'd1) begin
						wid_q[i] <= out_cfg_q[i].width;
					end
				end else if (wid_q[i] != 0) begin
					wid_q[i] <= wid_q[i] - 1'b1;
				end
				case (out_cfg_q[i].src)
					OSRC_EXPOSURE: gpio_out[i] <= out_cfg_q[i].invert ^ (exp_q & (wid_q[i] != 0));
					OSRC_TRIGGER:  gpio_out[i] <= out_cfg_q[i].invert ^ line_trigger_input;
					OSRC_HIGH:     gpio_out[i] <= ~out_cfg_q[i].invert;
					default:       gpio_out[i] <= out_cfg_q[i].invert;
				endcase
			end
		end
	end

	// ============================================================
	// checks
	property p_ack;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(avs_read && avs_waitrequest) |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_ro;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		trig_rise |=> readout_start_out;
	endproperty
	a_ro: assert property (p_ro) else $error("readout not started");
	property p_clamp;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(s1_q.valid && (mode_gain_q || !busy_q)) |->
			!s1_val_q[20] || pedestal_offset_q[15];
	endproperty
	a_clamp: assert property (p_clamp) else $error("negative not clamped");
	property p_sg;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		sys_gain_q >= UNITY_GAIN && sys_gain_q <= 16'(SYS_GAIN_MAX);
	endproperty
	a_sg: assert property (p_sg) else $error("system gain out of range");
	property p_rg;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		row_gain_q[0] >= UNITY_GAIN && row_gain_q[0] <= 16'(ROW_GAIN_MAX) &&
		row_gain_q[1] >= UNITY_GAIN && row_gain_q[1] <= 16'(ROW_GAIN_MAX);
	endproperty
	a_rg: assert property (p_rg) else $error("row gain out of range");
	property p_ds;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		dscale_q <= 17'((PERIOD_LO_CYC << GAIN_FRAC) / FACT_PERIOD_CYC);
	endproperty
	a_ds: assert property (p_ds) else $error("dark scale beyond band");
	property p_pipe;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		s0_q.valid |-> ##3 pix_out.valid;
	endproperty
	a_pipe: assert property (p_pipe) else $error("pixel lost in pipeline");
	property p_cal;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		cmem_we |-> busy_q || $past(busy_q);
	endproperty
	a_cal: assert property (p_cal) else $error("coefficients written outside calibration");
	c_pix: cover property (@(posedge ref_clk_in) pix_out.valid && pix_out.last);
	c_cal: cover property (@(posedge ref_clk_in) $fell(busy_q));
	c_gpio: cover property (@(posedge ref_clk_in) $rose(gpio_out[0]));
endmodule
`default_nettype wire

// ===== verif/fg_model.sv
`default_nettype none
module fg_model
	import pixcorr_pkg::*;
(
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire pix_s pix_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PIX_W-1:0] got [NUM_PIX];
	int               idx;
	int               last_idx;
	int               nlines;
	// ========================================
	// line capture, restarting after each end-of-line marker
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			idx = 0;
			last_idx = -1;
			nlines = 0;
		end else if (pix_in.valid === 1'b1) begin
			if (idx < NUM_PIX)
				got[idx] = pix_in.data;
			if (pix_in.last === 1'b1) begin
				last_idx = idx;
				nlines = nlines + 1;
				idx = 0;
			end else begin
				idx = idx + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/test_pixel_correction_and_strobe.sv
`default_nettype none
module test_pixel_correction_and_strobe
	import pixcorr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                ref_clk_in;
	logic                rst_n_in;
	logic [7:0]          avs_address;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_writedata;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic                line_trigger_input;
	pix_s                sensor_pix_in;
	logic                readout_start_out;
	pix_s                pix_out;
	logic [NUM_OUTS-1:0] gpio_out;
	int                  num_errors;
	int                  cmp_count;
	int                  n_win, n_rd, n_g0, n_g2, n_g3, n_same;
	int                  n_first, exp_lines;
	logic                mon;
	logic [31:0]         rd;

	pixel_correction_and_strobe u_dut (
		.ref_clk_in         (ref_clk_in),
		.rst_n_in           (rst_n_in),
		.avs_address        (avs_address),
		.avs_read           (avs_read),
		.avs_write          (avs_write),
		.avs_writedata      (avs_writedata),
		.avs_readdata       (avs_readdata),
		.avs_waitrequest    (avs_waitrequest),
		.line_trigger_input (line_trigger_input),
		.sensor_pix_in      (sensor_pix_in),
		.readout_start_out  (readout_start_out),
		.pix_out            (pix_out),
		.gpio_out           (gpio_out)
	);

	fg_model u_fg (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.pix_in     (pix_out)
	);

	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	// ========================================
	// strobe and readout observation during one line
	always @(posedge ref_clk_in) begin
		if (mon) begin
			n_win++;
			n_rd += 32'(readout_start_out === 1'b1);
			n_g0 += 32'(gpio_out[0] === 1'b1);
			n_g2 += 32'(gpio_out[2] === 1'b1);
			n_g3 += 32'(gpio_out[3] !== 1'b0);
			n_same += 32'(gpio_out[1] === gpio_out[0]);
			if (gpio_out[0] === 1'b1 && n_first == 0) begin
				n_first = n_win;
			end
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("mismatches=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ========================================
	// avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			num_errors++;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	// pixel value is base plus, optionally, a per-pixel pattern of 0..15
	task automatic run_line(input logic use_off, input logic [PIX_W-1:0] add);
		@(posedge ref_clk_in);
		line_trigger_input <= 1'b1;
		repeat (14) @(posedge ref_clk_in);
		for (int i = 0; i < NUM_PIX; i++) begin
			sensor_pix_in.valid <= 1'b1;
			sensor_pix_in.last  <= (i == NUM_PIX - 1);
			sensor_pix_in.data  <= (use_off ? PIX_W'(i % 16) : PIX_W'(0)) + add;
			@(posedge ref_clk_in);
		end
		sensor_pix_in      <= '0;
		line_trigger_input <= 1'b0;
		repeat (20) @(posedge ref_clk_in);
		exp_lines++;
	endtask

	task automatic check_line(input logic [PIX_W-1:0] exp);
		for (int i = 0; i < NUM_PIX; i++)
			check(32'(u_fg.got[i]), 32'(exp));
		check(32'(u_fg.last_idx), 32'(NUM_PIX - 1));
		check(32'(u_fg.nlines), 32'(exp_lines));
	endtask

	task automatic calibrate(input logic [31:0] ctrl, input logic [PIX_W-1:0] add);
		int k;
		k = 0;
		bus(1'b1, REG_CTRL, ctrl);
		repeat (CALIB_LINES) run_line(1'b1, add);
		do begin
			bus(1'b0, REG_STATUS, 32'h0000_0000);
			k++;
		end while (rd[0] !== 1'b0 && k < 200);
		check(32'(rd[0]), 32'h0000_0000);
	endtask

	// ========================================
	// main sequence
	initial begin
		rst_n_in = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		line_trigger_input = 1'b0;
		sensor_pix_in = '0;
		mon = 1'b0;
		{num_errors, cmp_count, n_win, n_rd, n_g0, n_g2, n_g3, n_same} = '0;
		{n_first, exp_lines} = '0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rchk(REG_STATUS, 32'h0000_0000);
		rchk(8'hFC, UNMAPPED_VAL);
		bus(1'b1, REG_ROW_GAIN0, 32'h0000_0000);
		rchk(REG_ROW_GAIN0, {16'h0000, UNITY_GAIN});
		bus(1'b1, REG_ROW_GAIN0, 32'h0000_FFFF);
		rchk(REG_ROW_GAIN0, 32'h0000_3FFF);
		bus(1'b1, REG_SYS_GAIN, 32'h0000_FFFF);
		rchk(REG_SYS_GAIN, 32'h0000_A000);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, REG_CTRL, 32'(m * 16 + 1));
			rchk(REG_CTRL, 32'(m * 16 + 1));
		end
		bus(1'b1, REG_SYS_GAIN, 32'h0000_1000);
		bus(1'b1, REG_ROW_GAIN0, 32'h0000_1000);
		bus(1'b1, REG_TARGET, 32'h0000_07D0);
		calibrate(32'h0001_0011, 12'h000);
		calibrate(32'h0002_0011, 12'h3E8);
		// light pulse delayed by the minimum wait after the trigger edge
		bus(1'b1, REG_OUT0, 32'h0204_6005);
		bus(1'b1, REG_OUT0 + 8'h04, 32'h0304_6005);
		bus(1'b1, REG_OUT0 + 8'h08, 32'h0600_0000);
		bus(1'b1, REG_OUT0 + 8'h0C, 32'h0000_0000);
		mon <= 1'b1;
		run_line(1'b1, 12'h1F4);
		mon <= 1'b0;
		check_line(12'h3E8);
		check(32'(n_rd), 32'h0000_0001);
		check(32'(n_g0), 32'h0000_0005);
		check(32'(n_same), 32'h0000_0000);
		check(32'(n_g2), 32'(n_win));
		check(32'(n_g3), 32'h0000_0000);
		check(32'(n_first > STROBE_MIN_CYCLES), 32'h0000_0001);
		run_line(1'b0, 12'h000);
		check_line(12'h000);
		bus(1'b1, REG_PEDESTAL, 32'h0000_0005);
		bus(1'b1, REG_ROW_GAIN0, 32'h0000_2000);
		run_line(1'b1, 12'h1F4);
		check_line(12'h7DA);
		bus(1'b1, REG_SYS_GAIN, 32'h0000_A000);
		run_line(1'b1, 12'h1F4);
		check_line(12'hFFF);
		bus(1'b1, REG_SYS_GAIN, 32'h0000_1000);
		bus(1'b1, REG_ROW_GAIN0, 32'h0000_1000);
		bus(1'b1, REG_PEDESTAL, 32'h0000_FE0C);
		run_line(1'b1, 12'h1F4);
		check_line(12'h1F4);
		summarize();
	end

	// hang guard, far beyond the length of the sequence
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
